// >>> inc/csc_cfg.svh
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

`define SOCK_ADDR_W        12
`define OFF_CSC_STATUS     12'h804
`define OFF_CSC_CONFIG     12'h805
`define OFF_WIN_ENABLE     12'h806
`define OFF_CSC_CONTROL    12'h830
`define CFG_RESET          8'h00
`define WIN_RESET          8'h00
`define CTL_RESET          8'h00
`define WIN_WRITE_MASK     8'hDF
`define CFG_SEL_HI         7
`define CFG_SEL_LO         4
`define SEL_NONE           4'h0
`define SEL_SMI            4'h2
`define CTL_DIAG_CSC_BIT   0
`define CTL_ROUTE_BIT      1
`define CTL_W1C_MODE_BIT   2
`define CTL_IOCARD_BIT     3
`define WIN_IO1_BIT        7
`define WIN_IO0_BIT        6
`define NUM_MEM_WIN        5
`define NUM_SRC            4

`endif

// >>> inc/csc_pkg.sv
package csc_pkg;
	typedef struct packed {
		logic [3:0] cscIrqSelect;
		logic       cardDetectIrqEn;
		logic       readyRiseIrqEn;
		logic       batteryWarnIrqEn;
		logic       batteryDeadIrqEn;
	} csc_config_t;

	typedef struct packed {
		logic       ioWindow1En;
		logic       ioWindow0En;
		logic       reserved;
		logic [4:0] memWindowEn;
	} win_enable_t;

	typedef struct packed {
		logic [15:1] isaIrq;
		logic        systemManagementIrq;
		logic        pciIrq;
	} irq_out_t;

	typedef enum logic [1:0] {
		ACC_IDLE  = 2'b00,
		ACC_READ  = 2'b01,
		ACC_WRITE = 2'b11
	} acc_state_t;
endpackage

// >>> design/csc_flag_bank.sv
`include "csc_cfg.svh"

module csc_flag_bank (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic [`NUM_SRC-1:0]   srcEvent,
	input  wire logic [`NUM_SRC-1:0]   srcEnable,
	input  wire logic                  clrByRead,
	input  wire logic                  clrByWrite,
	input  wire logic [`NUM_SRC-1:0]   clrMask,
	output logic      [`NUM_SRC-1:0]   flags_ff
);
	genvar i;
	generate
		for (i = 0; i < `NUM_SRC; i++) begin : g_flag
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					flags_ff[i] <= 1'b0;
				end else if (!srcEnable[i]) begin
					flags_ff[i] <= 1'b0;
				end else if (srcEvent[i]) begin
					// set beats a clear arriving the same cycle
					flags_ff[i] <= 1'b1;
				end else if (clrByRead || (clrByWrite && clrMask[i])) begin
					flags_ff[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule

// >>> design/csc_irq_router.sv
`include "csc_cfg.svh"

module csc_irq_router (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  anyFlag,
	input  wire logic [3:0]            cscIrqSelect,
	input  wire logic                  diagCsc,
	input  wire logic                  cscToPciRoute,
	output csc_pkg::irq_out_t          irq_ff
);
	csc_pkg::irq_out_t nxt_irq;

	always_comb begin
		nxt_irq = '0;
		if (cscIrqSelect == `SEL_NONE) begin
			// diag bit set makes the route bit a don't-care
			nxt_irq.pciIrq = anyFlag && (diagCsc || cscToPciRoute);
		end else if (cscIrqSelect == `SEL_SMI) begin
			nxt_irq.systemManagementIrq = anyFlag;
		end else begin
			for (int n = 1; n < 16; n++) begin
				if (cscIrqSelect == 4'(n)) begin
					nxt_irq.isaIrq[n] = anyFlag;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_ff <= '0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end
endmodule

// >>> design/csc_window_regs.sv
`include "csc_cfg.svh"

// How it works
// - config bits 7-4 pick the status-change interrupt destination.
// - select zero with diagnostic bit set routes to PCI; reset setting.
// - select zero with diagnostic bit clear routes to PCI only if route bit.
// - code 0 PCI as above, code 2 management interrupt, others ISA line of that number.
// - bit 3 gates card detect changes on either detect pin.
// - bit 2 gates ready rising edge interrupts.
// - bit 1 gates battery warning interrupts.
// - bit 0 gates battery dead (memory) or status pin (I/O card).
// - all source enables reset to zero.
// - a disabled window never claims a cycle aimed at the card.
// - window enable bit 7 is I/O window 1, bit 6 I/O window 0.
// - window enable bits 4-0 enable memory windows 4-0.
// - window enable bit 5 reads zero and ignores writes.
// - window enable register resets to 00h.
// - config at 805h, window enable at 806h.
// - disabled source flag reads zero; enabled active source sets its flag.
// - flags clear on status read or by writing one, per clear mode.
module csc_window_regs (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic                     regRead,
	input  wire logic                     regWrite,
	input  wire logic [`SOCK_ADDR_W-1:0]  regAddr,
	input  wire logic [7:0]               regWdata,
	input  wire logic                     cardDetect1N,
	input  wire logic                     cardDetect2N,
	input  wire logic                     cardReady,
	input  wire logic                     batteryWarn,
	input  wire logic                     batteryDead,
	input  wire logic                     statusChangePinN,
	input  wire logic                     ioWinHit1,
	input  wire logic                     ioWinHit0,
	input  wire logic [`NUM_MEM_WIN-1:0]  memWinHit,
	output logic      [7:0]               regRdata_ff,
	output logic                          regRvalid_ff,
	output logic                          cycleClaim_ff,
	output csc_pkg::win_enable_t          winEnable_ff,
	output csc_pkg::irq_out_t             irqOut
);
	csc_pkg::csc_config_t  cscConfig_ff;
	logic [7:0]            control_ff;
	logic                  cd1Prev_ff;
	logic                  cd2Prev_ff;
	logic                  readyPrev_ff;
	logic                  warnPrev_ff;
	logic                  deadPrev_ff;
	logic [`NUM_SRC-1:0]   flags;
	logic [`NUM_SRC-1:0]   srcEvent;
	logic [`NUM_SRC-1:0]   srcEnable;
	logic                  ioCard;
	logic                  w1cMode;
	logic                  statusRead;
	logic                  statusWrite;
	logic [7:0]            nxt_rdata;
	logic                  nxt_claim;

	assign ioCard = control_ff[`CTL_IOCARD_BIT];
	assign w1cMode = control_ff[`CTL_W1C_MODE_BIT];
	assign statusRead = regRead && (regAddr == `OFF_CSC_STATUS);
	assign statusWrite = regWrite && (regAddr == `OFF_CSC_STATUS);

	// configuration register write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cscConfig_ff <= `CFG_RESET;
		end else if (regWrite && regAddr == `OFF_CSC_CONFIG) begin
			cscConfig_ff <= regWdata;
		end
	end

	// window enable register write; bit 5 held at zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			winEnable_ff <= `WIN_RESET;
		end else if (regWrite && regAddr == `OFF_WIN_ENABLE) begin
			winEnable_ff <= regWdata & `WIN_WRITE_MASK;
		end
	end

	// local control: diag csc, route, clear mode, card type
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			control_ff <= `CTL_RESET;
			control_ff[`CTL_DIAG_CSC_BIT] <= 1'b1;
		end else if (regWrite && regAddr == `OFF_CSC_CONTROL) begin
			control_ff <= {4'h0, regWdata[3:0]};
		end
	end

	// previous levels for edge detection
	always_ff @(posedge clk) begin
		// track the pins through reset too, so release never shows a false edge
		cd1Prev_ff <= cardDetect1N;
		cd2Prev_ff <= cardDetect2N;
		readyPrev_ff <= cardReady;
		warnPrev_ff <= batteryWarn;
		deadPrev_ff <= ioCard ? !statusChangePinN : batteryDead;
	end

	always_comb begin
		srcEvent[3] = (cd1Prev_ff != cardDetect1N) || (cd2Prev_ff != cardDetect2N);
		srcEvent[2] = !ioCard && cardReady && !readyPrev_ff;
		srcEvent[1] = !ioCard && batteryWarn && !warnPrev_ff;
		srcEvent[0] = (ioCard ? !statusChangePinN : batteryDead) && !deadPrev_ff;
		srcEnable = {cscConfig_ff.cardDetectIrqEn, cscConfig_ff.readyRiseIrqEn,
			cscConfig_ff.batteryWarnIrqEn, cscConfig_ff.batteryDeadIrqEn};
	end

	csc_flag_bank u_flags (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.srcEvent   (srcEvent),
		.srcEnable  (srcEnable),
		.clrByRead  (statusRead && !w1cMode),
		.clrByWrite (statusWrite && w1cMode),
		.clrMask    (regWdata[`NUM_SRC-1:0]),
		.flags_ff   (flags)
	);

	csc_irq_router u_router (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.anyFlag       (|flags),
		.cscIrqSelect  (cscConfig_ff.cscIrqSelect),
		.diagCsc       (control_ff[`CTL_DIAG_CSC_BIT]),
		.cscToPciRoute (control_ff[`CTL_ROUTE_BIT]),
		.irq_ff        (irqOut)
	);

	// read mux; unmapped offsets read zero
	always_comb begin
		case (regAddr)
			`OFF_CSC_STATUS:  nxt_rdata = {4'h0, flags};
			`OFF_CSC_CONFIG:  nxt_rdata = cscConfig_ff;
			`OFF_WIN_ENABLE:  nxt_rdata = winEnable_ff;
			`OFF_CSC_CONTROL: nxt_rdata = control_ff;
			default:          nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRdata_ff <= 8'h00;
			regRvalid_ff <= 1'b0;
		end else begin
			regRvalid_ff <= regRead;
			if (regRead) begin
				regRdata_ff <= nxt_rdata;
			end
		end
	end

	// claim only through an enabled window; decode hits alone never claim
	always_comb begin
		nxt_claim = (ioWinHit1 && winEnable_ff.ioWindow1En)
			|| (ioWinHit0 && winEnable_ff.ioWindow0En)
			|| (|(memWinHit & winEnable_ff.memWindowEn));
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cycleClaim_ff <= 1'b0;
		end else begin
			cycleClaim_ff <= nxt_claim;
		end
	end
endmodule

// >>> bench/card_model.sv
module card_model (
	output logic cardDetect1N,
	output logic cardDetect2N,
	output logic cardReady,
	output logic batteryWarn,
	output logic batteryDead,
	output logic statusChangePinN
);
	timeunit 1ns;
	timeprecision 1ps;
	// a seated memory card: detect pins low, status pin idle high
	initial begin
		{cardDetect1N, cardDetect2N, cardReady} = 3'h0;
		{batteryWarn, batteryDead, statusChangePinN} = 3'h1;
	end
	// rising sources fire once only, so indices 0-2 and 4 are used once per run; index 3 toggles a detect pin
	task automatic ev(input int i);
		case (i)
			0: batteryDead = 1'b1;
			1: batteryWarn = 1'b1;
			2: cardReady = 1'b1;
			4: statusChangePinN = 1'b0;
			default: cardDetect1N = ~cardDetect1N;
		endcase
	endtask
endmodule

// >>> bench/csc_regs_asserts.sv
`include "csc_cfg.svh"
module csc_regs_asserts (
	input wire logic                    clk,
	input wire logic                    sys_rst,
	input wire logic                    regRead,
	input wire logic                    regWrite,
	input wire logic [11:0]             regAddr,
	input wire logic [7:0]              regWdata,
	input wire logic                    ioWinHit1,
	input wire logic                    ioWinHit0,
	input wire logic [4:0]              memWinHit,
	input wire logic [7:0]              regRdata_ff,
	input wire logic                    regRvalid_ff,
	input wire logic                    cycleClaim_ff,
	input wire csc_pkg::win_enable_t    winEnable_ff,
	input wire csc_pkg::irq_out_t       irqOut
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence sRdWin;
		regRead && regAddr == `OFF_WIN_ENABLE;
	endsequence
	sequence sWrWin;
		regWrite && regAddr == `OFF_WIN_ENABLE;
	endsequence
	AST_RVALID: assert property (regRead |=> regRvalid_ff)
		else $error("read answer missing");
	AST_WIN_WRITE: assert property (sWrWin |=> winEnable_ff == ($past(regWdata) & 8'hDF))
		else $error("window write not applied");
	AST_WIN_READ: assert property (sRdWin |=> regRdata_ff == $past(winEnable_ff))
		else $error("window readback wrong");
	AST_RESERVED: assert property (!winEnable_ff.reserved)
		else $error("reserved window bit set");
	AST_CLAIM: assert property (cycleClaim_ff ==
		$past(|({ioWinHit1, ioWinHit0, 1'b0, memWinHit} & winEnable_ff)))
		else $error("claim disagrees with enables");
	AST_NO_LINE2: assert property (!irqOut.isaIrq[2])
		else $error("line 2 driven");
	AST_ONE_LINE: assert property ($onehot0(irqOut[16:1]))
		else $error("several legacy lines driven");
	AST_AFTER_RST: assert property ($fell(sys_rst) |-> winEnable_ff == 8'h00 && irqOut == '0)
		else $error("outputs not cleared by reset");
endmodule
bind csc_window_regs csc_regs_asserts chk (.*);

// >>> bench/tb_top.sv
`include "csc_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, sys_rst = 1, regRead = 0, regWrite = 0, ioWinHit1 = 0, ioWinHit0 = 0;
	logic [11:0] regAddr = 12'h000;
	logic [7:0] regWdata = 8'h00, regRdata_ff;
	logic [4:0] memWinHit = 5'h00;
	logic cardDetect1N, cardDetect2N, cardReady, batteryWarn, batteryDead, statusChangePinN;
	logic regRvalid_ff, cycleClaim_ff;
	csc_pkg::win_enable_t winEnable_ff;
	csc_pkg::irq_out_t irqOut, none = '0, pci = 17'h00001;
	int error_cnt = 0, total_checks = 0;
	always #2 clk = ~clk;
	csc_window_regs uut (.*);
	card_model card (.*);
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chkByte(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkIrq(input string n, input csc_pkg::irq_out_t e, input csc_pkg::irq_out_t g);
		chkByte({n, " hi"}, {7'h00, e[16]}, {7'h00, g[16]});
		chkByte({n, " mid"}, e[15:8], g[15:8]);
		chkByte({n, " lo"}, e[7:0], g[7:0]);
	endtask
	// strobe is dropped for a full cycle so a following call never re-drives it in one step
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		{regWrite, regAddr, regWdata} = {1'b1, a, d};
		cyc(1);
		regWrite = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
		{regRead, regAddr} = {1'b1, a};
		cyc(1);
		regRead = 1'b0;
		chkByte("rvalid", 8'h01, {7'h00, regRvalid_ff});
		chkByte(n, e, regRdata_ff);
		cyc(1);
	endtask
	function automatic csc_pkg::irq_out_t expIrq(input logic [3:0] s);
		expIrq = '0;
		if (s == 4'h0) expIrq.pciIrq = 1'b1;
		else if (s == 4'h2) expIrq.systemManagementIrq = 1'b1;
		else expIrq.isaIrq[s] = 1'b1;
	endfunction
	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		cyc(5);
		sys_rst = 1'b0;
		rd(12'h805, 8'h00, "config");
		rd(12'h806, 8'h00, "window");
		rd(12'h8FF, 8'h00, "unmapped");
		wr(12'h806, 8'hFF);
		rd(12'h806, 8'hDF, "window");
		for (int b = 0; b < 8; b++) begin
			{ioWinHit1, ioWinHit0, memWinHit} = {b == 7, b == 6, 5'(8'h01 << b)};
			wr(12'h806, ~(8'h01 << b));
			cyc(1);
			chkByte("claim off", 8'h00, {7'h00, cycleClaim_ff});
			wr(12'h806, 8'h01 << b);
			cyc(1);
			chkByte("claim on", {7'h00, b != 5}, {7'h00, cycleClaim_ff});
		end
		{ioWinHit1, ioWinHit0, memWinHit} = 7'h00;
		wr(12'h805, 8'hF7);
		card.ev(3);
		cyc(3);
		chkIrq("masked", none, irqOut);
		rd(12'h804, 8'h00, "masked flags");
		for (int i = 0; i < 4; i++) begin
			wr(12'h805, 8'hF0 | (8'h01 << i));
			card.ev(i);
			cyc(3);
			chkIrq("source", expIrq(4'hF), irqOut);
			rd(12'h804, 8'h01 << i, "flags");
		end
		for (int s = 0; s < 16; s++) begin
			wr(12'h805, {4'(s), 4'h8});
			card.ev(3);
			cyc(3);
			chkIrq("route", expIrq(4'(s)), irqOut);
			rd(12'h804, 8'h08, "flags");
			cyc(2);
			chkIrq("released", none, irqOut);
		end
		wr(12'h805, 8'h08);
		wr(12'h830, 8'h00);
		card.ev(3);
		cyc(3);
		chkIrq("no route", none, irqOut);
		wr(12'h830, 8'h02);
		cyc(2);
		chkIrq("route bit", pci, irqOut);
		wr(12'h830, 8'h05);
		rd(12'h804, 8'h08, "flags");
		cyc(2);
		chkIrq("kept", pci, irqOut);
		wr(12'h804, 8'h08);
		cyc(2);
		chkIrq("cleared", none, irqOut);
		wr(12'h830, 8'h09);
		wr(12'h805, 8'h01);
		card.ev(4);
		cyc(3);
		chkIrq("io status pin", pci, irqOut);
		rd(12'h804, 8'h01, "io flags");
		sys_rst = 1'b1;
		cyc(2);
		sys_rst = 1'b0;
		rd(12'h806, 8'h00, "window");
		rd(12'h805, 8'h00, "config");
		conclude();
	end
	initial begin
		#100000;
		error_cnt++;
		conclude();
	end
endmodule
